// ### shared/skew_recovery_pkg.sv
// Purpose: constants for the skew and recovery frequency register bank
// Assumes: byte-wide registers reached by offset from the serial front end
// Notes:   all registers clear to zero at reset except the mode, which loads ModeNormal
package skew_recovery_pkg;
    // register offsets
    localparam logic [7:0] SkewOffset    = 8'h0a;
    localparam logic [7:0] RecNOffset    = 8'h0b;
    localparam logic [7:0] RecMOffset    = 8'h0c;
    localparam logic [7:0] CtrlOffset    = 8'h09;
    // field positions in the skew register
    localparam int         CpuSkewLsb    = 5;
    localparam int         MemSkewLsb    = 2;
    localparam int         GfxSkewLsb    = 0;
    // field positions in the control and M registers
    localparam int         OverrideBit   = 5;
    localparam int         WdEnableBit   = 1;
    localparam int         RecSelBit     = 7;
    // reset values
    localparam logic [7:0] SkewReset     = 8'h00;
    localparam logic [7:0] RecNReset     = 8'h00;
    localparam logic [6:0] RecMReset     = 7'h00;
    localparam logic [4:0] SelReset      = 5'h00;
    // frequency range limits in MHz
    localparam int         FreqMinMhz    = 50;
    localparam int         FreqMaxMhz    = 248;
    // pipeline depth of the pin input synchroniser
    localparam int         SyncStages    = 3;

    typedef enum logic [1:0] {
        ModeNormal   = 2'b01,
        ModeRecovery = 2'b10
    } freq_mode_t;
endpackage

// ### test/skew_and_recovery_freq_regs_asserts.sv
`timescale 1ns/10ps
// Purpose: port checks for the skew and recovery bank
// Assumes: byte strobes are one cycle wide
// Notes:   bound to every instance of the bank
module skew_and_recovery_freq_regs_asserts (
    // clock, reset and register access
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic       regRdValid,
    // outputs to the delay lines and the synthesizer
    input wire logic [2:0] cpuClockDelaySel,
    input wire logic [2:0] memClockDelaySel,
    input wire logic [1:0] graphicsClockDelaySel,
    input wire logic [7:0] synthN,
    input wire logic       freqChange,
    input wire logic       recoveryLocked
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire [7:0] skew = {cpuClockDelaySel, memClockDelaySel,
                       graphicsClockDelaySel};
    wire       wrS = regWrite && regAddr == skew_recovery_pkg::SkewOffset;
    wire       wrN = regWrite && regAddr == skew_recovery_pkg::RecNOffset;
    wire       wrC = regWrite && regAddr == skew_recovery_pkg::CtrlOffset;
    wire       rdS = regRead && regAddr == skew_recovery_pkg::SkewOffset;
    a_skew_write: assert property (wrS |=> skew == $past(regWrData))
        else $error("skew fields differ from written byte");
    a_n_applied: assert property (wrN && !recoveryLocked |=>
        synthN == $past(regWrData) && freqChange)
        else $error("N write not applied");
    a_locked_hold: assert property (wrN && recoveryLocked |=>
        $stable(synthN) && !freqChange)
        else $error("N write changed frequency while locked");
    a_lock_change: assert property ($rose(recoveryLocked) |-> freqChange)
        else $error("lock without frequency change");
    a_lock_keep: assert property (recoveryLocked && !wrC |=> recoveryLocked)
        else $error("lock dropped without control write");
    a_skew_read: assert property (rdS |=> regRdData == $past(skew))
        else $error("skew read back wrong");
    a_read_idle: assert property (!regRdValid |-> regRdData == 8'h00)
        else $error("read data not zero when idle");
    a_read_answer: assert property (regRead |=> regRdValid)
        else $error("read not answered next cycle");
    c_n_change: cover property (wrN ##1 freqChange);
    c_lock: cover property ($rose(recoveryLocked));
    c_locked_write: cover property (wrN && recoveryLocked);
endmodule
bind skew_and_recovery_freq_regs skew_and_recovery_freq_regs_asserts chk (
    .clock(clock), .sys_rst(sys_rst), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .synthN(synthN),
    .cpuClockDelaySel(cpuClockDelaySel), .freqChange(freqChange),
    .memClockDelaySel(memClockDelaySel), .recoveryLocked(recoveryLocked),
    .graphicsClockDelaySel(graphicsClockDelaySel));

// ### test/skew_and_recovery_freq_regs_tb.sv
`timescale 1ns/10ps
// Purpose: self-checking bench for the skew and recovery bank
// Assumes: strap pins set before reset release and held steady
// Notes:   inputs change on the falling clock edge
module skew_and_recovery_freq_regs_tb;
    logic       clock, sys_rst, watchdogTimeout, v;
    logic       regWrite, regRead, regRdValid, freqChange;
    logic       recoveryLocked, useProgrammedNm;
    logic [4:0] strapFrequencySelect, softFrequencySelect, ratioSelect;
    logic [7:0] regAddr, regWrData, regRdData, synthN, rd, n, b;
    logic [2:0] cpuClockDelaySel, memClockDelaySel;
    logic [1:0] graphicsClockDelaySel;
    logic [6:0] synthM;
    int         mismatches, checks, cycles, seed;

    skew_and_recovery_freq_regs uut (.clock(clock), .sys_rst(sys_rst),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .watchdogTimeout(watchdogTimeout),
        .strapFrequencySelect(strapFrequencySelect),
        .softFrequencySelect(softFrequencySelect),
        .cpuClockDelaySel(cpuClockDelaySel),
        .memClockDelaySel(memClockDelaySel),
        .graphicsClockDelaySel(graphicsClockDelaySel),
        .ratioSelect(ratioSelect), .useProgrammedNm(useProgrammedNm),
        .synthN(synthN), .synthM(synthM), .freqChange(freqChange),
        .recoveryLocked(recoveryLocked));
    skew_host_model host (.clock(clock), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [4:0] expRatio(logic ov, logic [4:0] s, t);
        return ov ? s : t;
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end
    // arm, trip the watchdog, try a locked write, then unlock
    task automatic wdTrip(input logic sel);
        int k;
        n = 8'($random(seed));
        host.wnm(n, {sel, 7'h15});
        host.wr(skew_recovery_pkg::CtrlOffset, 8'h02);
        watchdogTimeout = 1'b1;
        k = 0;
        while (freqChange !== 1'b1 && k < 10) begin
            @(negedge clock);
            k++;
        end
        chk("wdChange", 8'h01, freqChange);
        chk("locked", 8'h01, recoveryLocked);
        chk("useNm", sel, useProgrammedNm);
        chk("wdN", n, synthN);
        host.wr(skew_recovery_pkg::RecNOffset, ~n);
        chk("lockN", n, synthN);
        host.rd(skew_recovery_pkg::RecNOffset, rd, v);
        chk("lockRd", n, rd);
        host.wr(skew_recovery_pkg::CtrlOffset, 8'h00);
        watchdogTimeout = 1'b0;
        @(negedge clock);
        chk("unlock", 8'h00, recoveryLocked);
    endtask

    initial begin
        seed = 32'h91ab1de2;
        sys_rst = 1'b1;
        watchdogTimeout = 1'b0;
        strapFrequencySelect = 5'($random(seed));
        softFrequencySelect = 5'h00;
        repeat (8) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        host.rd(skew_recovery_pkg::SkewOffset, rd, v);
        chk("skewRst", 8'h00, rd);
        host.rd(skew_recovery_pkg::RecNOffset, rd, v);
        chk("nRst", 8'h00, rd);
        host.rd(8'h3f, rd, v);
        chk("rdValid", 8'h01, v);
        chk("unmapped", 8'h00, rd);
        for (int i = 0; i < 12; i++) begin
            b = (i < 8) ? {3'(i), 3'(7 - i), 2'(i)} : 8'($random(seed));
            host.wr(skew_recovery_pkg::SkewOffset, b);
            chk("cpuSkew", b[7:5], cpuClockDelaySel);
            chk("memSkew", b[4:2], memClockDelaySel);
            chk("gfxSkew", b[1:0], graphicsClockDelaySel);
            host.rd(skew_recovery_pkg::SkewOffset, rd, v);
            chk("skewRd", b, rd);
        end
        n = 8'($random(seed));
        host.wr(skew_recovery_pkg::RecNOffset, n);
        chk("nChange", 8'h01, freqChange);
        chk("synthN", n, synthN);
        host.wr(skew_recovery_pkg::RecMOffset, {1'b0, n[6:0]});
        chk("mChange", 8'h01, freqChange);
        chk("synthM", n[6:0], synthM);
        softFrequencySelect = strapFrequencySelect ^
                              (5'($random(seed)) | 5'h01);
        host.wr(skew_recovery_pkg::CtrlOffset, 8'h20);
        repeat (2) @(negedge clock);
        chk("ratioSoft", expRatio(1'b1, softFrequencySelect,
            strapFrequencySelect), ratioSelect);
        host.wr(skew_recovery_pkg::CtrlOffset, 8'h00);
        repeat (2) @(negedge clock);
        chk("ratioStrap", expRatio(1'b0, softFrequencySelect,
            strapFrequencySelect), ratioSelect);
        wdTrip(1'b1);
        wdTrip(1'b0);
        final_report();
    end
endmodule

// ### test/skew_host_model.sv
`timescale 1ns/10ps
// Purpose: management bus host model issuing byte accesses
// Assumes: the bank takes strobes on the rising clock edge
// Notes:   released data lines show the inverse of their last value
module skew_host_model (
    // clock
    input  wire logic       clock,
    // register access
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(negedge clock);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clock);
        v = regRdValid;
        d = regRdData;
        regRead = 1'b0;
    endtask
    // N then M in one burst, no other access between
    task automatic wnm(input logic [7:0] n, input logic [7:0] m);
        wr(skew_recovery_pkg::RecNOffset, n);
        wr(skew_recovery_pkg::RecMOffset, m);
    endtask
endmodule

// ### verilog/pin_sync.sv
`timescale 1ns/10ps
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to clock
// Notes:   output changes once stages two and three agree
module pin_sync #(
    parameter int Width = 1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // pin side
    input  wire logic [Width-1:0] pinIn,
    // synchronised side
    output logic      [Width-1:0] syncOut
);
    logic [Width-1:0] s1_q;
    logic [Width-1:0] s2_q;
    logic [Width-1:0] s3_q;
    logic [Width-1:0] out_d;
    logic [Width-1:0] out_q;

    genvar i;
    generate
        for (i = 0; i < Width; i++) begin : gAgree
            always_comb begin
                out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= pinIn;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign syncOut = out_q;
endmodule

// ### verilog/skew_and_recovery_freq_regs.sv
`timescale 1ns/10ps
// Purpose: skew selection and recovery frequency register bank
// Assumes: serial front end delivers byte reads and writes by offset
// Notes:   the synthesizer consumes the selected source and change pulse
module skew_and_recovery_freq_regs (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // register access from the serial management front end
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    output logic            regRdValid,
    // strap and software frequency selects
    input  wire logic [4:0] strapFrequencySelect,
    input  wire logic [4:0] softFrequencySelect,
    // watchdog
    input  wire logic       watchdogTimeout,
    // skew selections
    output logic      [2:0] cpuClockDelaySel,
    output logic      [2:0] memClockDelaySel,
    output logic      [1:0] graphicsClockDelaySel,
    // synthesizer controls
    output logic      [4:0] ratioSelect,
    output logic            useProgrammedNm,
    output logic      [7:0] synthN,
    output logic      [6:0] synthM,
    output logic            freqChange,
    output logic            recoveryLocked
);
    logic [4:0] strapSync;
    logic [2:0] strapCnt_q;
    logic [2:0] strapCnt_d;
    logic [4:0] strapLatch_q;
    logic [4:0] strapLatch_d;
    logic       strapDone_q;
    logic       strapDone_d;
    logic       wdSync;

    // strap pins and watchdog come from outside this domain
    pin_sync #(.Width(5)) uStrapSync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pinIn   (strapFrequencySelect),
        .syncOut (strapSync)
    );
    pin_sync #(.Width(1)) uWdSync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pinIn   (watchdogTimeout),
        .syncOut (wdSync)
    );

    logic [7:0] skew_q;
    logic [7:0] skew_d;
    logic [7:0] recN_q;
    logic [7:0] recN_d;
    logic [6:0] recM_q;
    logic [6:0] recM_d;
    logic       recSel_q;
    logic       recSel_d;
    logic       override_q;
    logic       override_d;
    logic       wdEnable_q;
    logic       wdEnable_d;
    logic [4:0] sel_q;
    logic [4:0] sel_d;
    logic       wdPrev_q;
    logic       wdPrev_d;
    logic [7:0] rd_q;
    logic [7:0] rd_d;
    logic       rdv_q;
    logic       rdv_d;
    logic       chg_q;
    logic       chg_d;
    logic [4:0] ratio_q;
    logic [4:0] ratio_d;
    logic       useNm_q;
    logic       useNm_d;
    logic [7:0] synN_q;
    logic [7:0] synN_d;
    logic [6:0] synM_q;
    logic [6:0] synM_d;
    skew_recovery_pkg::freq_mode_t mode_q;
    skew_recovery_pkg::freq_mode_t mode_d;

    logic wrSkew;
    logic wrN;
    logic wrM;
    logic wrCtrl;
    logic wdRise;
    logic locked;

    always_comb begin
        wrSkew = regWrite && regAddr == skew_recovery_pkg::SkewOffset;
        wrN    = regWrite && regAddr == skew_recovery_pkg::RecNOffset;
        wrM    = regWrite && regAddr == skew_recovery_pkg::RecMOffset;
        wrCtrl = regWrite && regAddr == skew_recovery_pkg::CtrlOffset;
        wdRise = wdSync && !wdPrev_q;
        locked = mode_q == skew_recovery_pkg::ModeRecovery;
    end

    // strap value latched once the synchroniser has settled after reset
    always_comb begin
        strapCnt_d   = strapDone_q ? strapCnt_q : strapCnt_q + 3'h1;
        strapDone_d  = strapDone_q ||
                       strapCnt_q == 3'(skew_recovery_pkg::SyncStages + 1);
        strapLatch_d = (strapDone_d && !strapDone_q) ? strapSync
                                                      : strapLatch_q;
    end

    // register storage
    always_comb begin
        skew_d     = wrSkew ? regWrData : skew_q;
        recN_d     = recN_q;
        recM_d     = recM_q;
        recSel_d   = recSel_q;
        override_d = override_q;
        wdEnable_d = wdEnable_q;
        sel_d      = softFrequencySelect;
        if (wrN && !locked) begin
            recN_d = regWrData;
        end
        if (wrM && !locked) begin
            recM_d   = regWrData[6:0];
            recSel_d = regWrData[skew_recovery_pkg::RecSelBit];
        end
        if (wrCtrl) begin
            wdEnable_d = regWrData[skew_recovery_pkg::WdEnableBit];
            if (!locked) begin
                override_d = regWrData[skew_recovery_pkg::OverrideBit];
            end
        end
    end

    // recovery mode: entered on time-out, left when watchdog disabled
    always_comb begin
        wdPrev_d = wdSync;
        mode_d   = mode_q;
        unique case (mode_q)
            skew_recovery_pkg::ModeNormal: begin
                if (wdRise && wdEnable_q) begin
                    mode_d = skew_recovery_pkg::ModeRecovery;
                end
            end
            skew_recovery_pkg::ModeRecovery: begin
                if (wrCtrl &&
                    !regWrData[skew_recovery_pkg::WdEnableBit]) begin
                    mode_d = skew_recovery_pkg::ModeNormal;
                end
            end
            default: mode_d = skew_recovery_pkg::ModeNormal;
        endcase
    end

    // synthesizer source selection
    always_comb begin
        ratio_d = override_q ? sel_q : strapLatch_q;
        useNm_d = useNm_q;
        synN_d  = synN_q;
        synM_d  = synM_q;
        chg_d   = 1'b0;
        if (!locked && (wrN || wrM)) begin
            // either byte alone retunes; the host should send both at once
            useNm_d = 1'b1;
            synN_d  = wrN ? regWrData : recN_q;
            synM_d  = wrM ? regWrData[6:0] : recM_q;
            chg_d   = 1'b1;
        end
        if (!locked && wdRise && wdEnable_q) begin
            useNm_d = recSel_q;
            synN_d  = recN_q;
            synM_d  = recM_q;
            if (!recSel_q) begin
                ratio_d = strapLatch_q;
            end
            chg_d = 1'b1;
        end
    end

    // read path
    always_comb begin
        rdv_d = regRead;
        rd_d  = 8'h00;
        if (regRead) begin
            if (regAddr == skew_recovery_pkg::SkewOffset) begin
                rd_d = skew_q;
            end else if (regAddr == skew_recovery_pkg::RecNOffset) begin
                rd_d = recN_q;
            end else if (regAddr == skew_recovery_pkg::RecMOffset) begin
                rd_d = {recSel_q, recM_q};
            end else if (regAddr == skew_recovery_pkg::CtrlOffset) begin
                rd_d = {2'h0, override_q, 3'h0, wdEnable_q, 1'b0};
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            strapLatch_q <= skew_recovery_pkg::SelReset;
            strapCnt_q   <= 3'h0;
            strapDone_q  <= 1'b0;
            skew_q       <= skew_recovery_pkg::SkewReset;
            recN_q       <= skew_recovery_pkg::RecNReset;
            recM_q       <= skew_recovery_pkg::RecMReset;
            recSel_q     <= 1'b0;
            override_q   <= 1'b0;
            wdEnable_q   <= 1'b0;
            sel_q        <= skew_recovery_pkg::SelReset;
            wdPrev_q     <= 1'b0;
            mode_q       <= skew_recovery_pkg::ModeNormal;
            rd_q         <= 8'h00;
            rdv_q        <= 1'b0;
            chg_q        <= 1'b0;
            ratio_q      <= skew_recovery_pkg::SelReset;
            useNm_q      <= 1'b0;
            synN_q       <= skew_recovery_pkg::RecNReset;
            synM_q       <= skew_recovery_pkg::RecMReset;
        end else begin
            strapLatch_q <= strapLatch_d;
            strapCnt_q   <= strapCnt_d;
            strapDone_q  <= strapDone_d;
            skew_q       <= skew_d;
            recN_q       <= recN_d;
            recM_q       <= recM_d;
            recSel_q     <= recSel_d;
            override_q   <= override_d;
            wdEnable_q   <= wdEnable_d;
            sel_q        <= sel_d;
            wdPrev_q     <= wdPrev_d;
            mode_q       <= mode_d;
            rd_q         <= rd_d;
            rdv_q        <= rdv_d;
            chg_q        <= chg_d;
            ratio_q      <= ratio_d;
            useNm_q      <= useNm_d;
            synN_q       <= synN_d;
            synM_q       <= synM_d;
        end
    end

    // skew codes go straight to the delay lines
    assign cpuClockDelaySel      = skew_q[skew_recovery_pkg::CpuSkewLsb +: 3];
    assign memClockDelaySel      = skew_q[skew_recovery_pkg::MemSkewLsb +: 3];
    assign graphicsClockDelaySel = skew_q[skew_recovery_pkg::GfxSkewLsb +: 2];
    // the synthesizer maps N and M to 50..248 MHz; no clamp is applied here
    assign synthN                = synN_q;
    assign synthM                = synM_q;
    assign ratioSelect           = ratio_q;
    assign useProgrammedNm       = useNm_q;
    assign freqChange            = chg_q;
    assign recoveryLocked        = mode_q[1];
    assign regRdData             = rd_q;
    assign regRdValid            = rdv_q;
endmodule
